// File: inc/bce_pkg.sv
// shared constants and types of the byte crc engine and its controller
package bce_pkg;

    ////////////////////////////////////////
    // register addresses on the device's own register port
    localparam logic [7:0] BCE_SFR_DATA = 8'h91;
    localparam logic [7:0] BCE_SFR_CTRL = 8'h92;
    localparam logic [7:0] BCE_SFR_INPUT = 8'h93;
    localparam logic [7:0] BCE_SFR_AUTO = 8'h96;
    localparam logic [7:0] BCE_SFR_COUNT = 8'h97;

    ////////////////////////////////////////
    // field positions and reset values
    localparam int BCE_CTRL_SEL_BIT = 4;
    localparam int BCE_CTRL_INIT_BIT = 3;
    localparam int BCE_CTRL_VAL_BIT = 2;
    localparam int BCE_CTRL_PTR_LSB = 0;
    localparam int BCE_AUTO_EN_BIT = 7;
    localparam int BCE_AUTO_IDX_W = 6;
    localparam logic [7:0] BCE_REG8_RST = 8'h00;
    localparam logic [31:0] BCE_RESULT_RST = 32'h0000_0000;

    ////////////////////////////////////////
    // polynomials and start values
    localparam logic [31:0] BCE_POLY32 = 32'h04C1_1DB7;
    localparam logic [15:0] BCE_POLY16 = 16'h1021;
    localparam logic [31:0] BCE_START_ZEROS = 32'h0000_0000;
    localparam logic [31:0] BCE_START_ONES = 32'hFFFF_FFFF;

    ////////////////////////////////////////
    // flash walk and buffering
    localparam int BCE_SECTOR_BYTES = 1024;
    localparam int BCE_SECTOR_SHIFT = $clog2(BCE_SECTOR_BYTES);
    localparam int BCE_FLASH_AW = 16;
    localparam int BCE_FIFO_DEPTH = 2;
    localparam int BCE_FIFO_W = 8;
    localparam int BCE_LEFT_W = 8 + BCE_SECTOR_SHIFT;

    ////////////////////////////////////////
    // controller bus map
    localparam logic [31:0] BCE_AHB_WINDOW_TOP = 32'h0000_0400;
    localparam logic [31:0] BCE_AHB_STATUS = 32'h0000_0400;

    typedef enum logic [4:0] {
        BCE_ST_IDLE = 5'b00001,
        BCE_ST_WDATA = 5'b00010,
        BCE_ST_ISSUE = 5'b00100,
        BCE_ST_WAIT = 5'b01000,
        BCE_ST_DONE = 5'b10000
    } bce_ctl_state_t;

endpackage

// File: inc/bce_link_if.sv
// register port between the controller and the crc engine
`timescale 1ns/1ps
interface bce_link_if;
    logic sfr_wr;
    logic sfr_rd;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic cpu_stall;

    modport ctl (
        output sfr_wr,
        output sfr_rd,
        output sfr_addr,
        output sfr_wdata,
        input sfr_rdata,
        input cpu_stall
    );

    modport dev (
        input sfr_wr,
        input sfr_rd,
        input sfr_addr,
        input sfr_wdata,
        output sfr_rdata,
        output cpu_stall
    );
endinterface

// File: design/bce_device.sv
// byte crc engine: register port, crc datapath, automatic flash walk
//
// Notes on behaviour
// - two polynomials, 0x1021 and 0x04C11DB7
// - select 0 gives 32-bit, 1 gives 16-bit
// - start value zeros for 0, ones for 1
// - init write loads chosen start value
// - each input byte XORed into top bits
// - eight shifts, polynomial XOR on top bit
// - result updates after every input byte
// - software programs sector index, enable, count
// - control write with auto enabled starts walk
// - cpu stalled until walk completes
// - software clears enable before reading result
// - pointer selects result byte, increments per access
// - result holds until init, write, input or walk byte
// - pointer codes map bytes; 16-bit aliases upper
//
// The AHB-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module bce_device
    import bce_pkg::*;
#(
    parameter int FLASH_AW = BCE_FLASH_AW,
    parameter int FIFO_DEPTH = BCE_FIFO_DEPTH,
    parameter int FIFO_W = BCE_FIFO_W
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // register port from the controller
    bce_link_if.dev link,
    // flash read requests
    output logic flash_req_valid,
    input wire logic flash_req_ready,
    output logic [FLASH_AW-1:0] flash_req_addr,
    // flash read data
    input wire logic flash_rsp_valid,
    output logic flash_rsp_ready,
    input wire logic [FIFO_W-1:0] flash_rsp_data,
    // status
    output logic auto_busy
);

    localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
    localparam int CNT_W = $clog2(FIFO_DEPTH + 1);

    ////////////////////////////////////////
    // state
    logic [31:0] result_reg;
    logic poly_sel_reg;
    logic val_sel_reg;
    logic [1:0] ptr_reg;
    logic [7:0] input_reg;
    logic [7:0] auto_reg;
    logic [7:0] count_reg;
    logic [7:0] rdata_reg;
    logic busy_reg;
    logic [BCE_LEFT_W-1:0] req_left_reg;
    logic [BCE_LEFT_W-1:0] use_left_reg;
    logic [FLASH_AW-1:0] req_addr_reg;
    logic [FIFO_W-1:0] fifo_mem [FIFO_DEPTH];
    logic [PTR_W-1:0] fifo_wr_reg;
    logic [PTR_W-1:0] fifo_rd_reg;
    logic [CNT_W-1:0] fifo_cnt_reg;

    ////////////////////////////////////////
    // decode
    logic wr_data;
    logic wr_ctrl;
    logic wr_input;
    logic wr_auto;
    logic wr_count;
    logic rd_data;
    logic init_req;
    logic start_walk;
    logic [1:0] byte_sel;
    logic fifo_full;
    logic fifo_valid;
    logic fifo_push;
    logic fifo_pop;
    logic req_fire;
    logic result_busy;

    assign wr_data = link.sfr_wr && (link.sfr_addr == BCE_SFR_DATA);
    assign wr_ctrl = link.sfr_wr && (link.sfr_addr == BCE_SFR_CTRL);
    assign wr_input = link.sfr_wr && (link.sfr_addr == BCE_SFR_INPUT);
    assign wr_auto = link.sfr_wr && (link.sfr_addr == BCE_SFR_AUTO);
    assign wr_count = link.sfr_wr && (link.sfr_addr == BCE_SFR_COUNT);
    assign rd_data = link.sfr_rd && (link.sfr_addr == BCE_SFR_DATA);
    assign init_req = wr_ctrl && link.sfr_wdata[BCE_CTRL_INIT_BIT];

    // in 16-bit mode codes 10 and 11 fold back onto the low two bytes
    assign byte_sel = poly_sel_reg ? {1'b0, ptr_reg[0]} : ptr_reg;

    // with enable set, a nonzero count and no walk running, any control write starts the walk; the written value is irrelevant
    assign start_walk = wr_ctrl && auto_reg[BCE_AUTO_EN_BIT] && !busy_reg && (count_reg != 8'h00);

    ////////////////////////////////////////
    // crc of one byte
    function automatic logic [31:0] crc_step(input logic [31:0] cur, input logic [7:0] din, input logic sel16);
        logic [31:0] acc;
        acc = sel16 ? {cur[31:16], cur[15:0] ^ {din, 8'h00}} : (cur ^ {din, 24'h00_0000});
        for (int i = 0; i < 8; i++) begin
            if (sel16) begin
                acc[15:0] = acc[15] ? ({acc[14:0], 1'b0} ^ BCE_POLY16) : {acc[14:0], 1'b0};
            end else begin
                acc = acc[31] ? ({acc[30:0], 1'b0} ^ BCE_POLY32) : {acc[30:0], 1'b0};
            end
        end
        return acc;
    endfunction

    ////////////////////////////////////////
    // control fields
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            poly_sel_reg <= 1'b0;
            val_sel_reg <= 1'b0;
        end else if (wr_ctrl) begin
            poly_sel_reg <= link.sfr_wdata[BCE_CTRL_SEL_BIT];
            val_sel_reg <= link.sfr_wdata[BCE_CTRL_VAL_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ptr_reg <= 2'b00;
        end else if (wr_ctrl) begin
            ptr_reg <= link.sfr_wdata[BCE_CTRL_PTR_LSB +: 2];
        end else if (wr_data || rd_data) begin
            ptr_reg <= ptr_reg + 2'b01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            input_reg <= BCE_REG8_RST;
            auto_reg <= BCE_REG8_RST;
            count_reg <= BCE_REG8_RST;
        end else begin
            if (wr_input) begin
                input_reg <= link.sfr_wdata;
            end
            if (wr_auto) begin
                auto_reg <= link.sfr_wdata;
            end
            if (wr_count) begin
                count_reg <= link.sfr_wdata;
            end
        end
    end

    ////////////////////////////////////////
    // result register; register writes take priority over flash bytes
    assign result_busy = init_req || wr_data || wr_input;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_reg <= BCE_RESULT_RST;
        end else if (init_req) begin
            // the start value follows the select bit written alongside
            result_reg <= link.sfr_wdata[BCE_CTRL_VAL_BIT] ? BCE_START_ONES : BCE_START_ZEROS;
        end else if (wr_data) begin
            result_reg[byte_sel*8 +: 8] <= link.sfr_wdata;
        end else if (wr_input) begin
            result_reg <= crc_step(result_reg, link.sfr_wdata, poly_sel_reg);
        end else if (fifo_pop) begin
            result_reg <= crc_step(result_reg, fifo_mem[fifo_rd_reg], poly_sel_reg);
        end
    end

    ////////////////////////////////////////
    // read data, one cycle after the read strobe
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_reg <= BCE_REG8_RST;
        end else if (link.sfr_rd) begin
            case (link.sfr_addr)
                BCE_SFR_DATA: rdata_reg <= result_reg[byte_sel*8 +: 8];
                BCE_SFR_CTRL: rdata_reg <= {3'b000, poly_sel_reg, 1'b0, val_sel_reg, ptr_reg};
                BCE_SFR_INPUT: rdata_reg <= input_reg;
                BCE_SFR_AUTO: rdata_reg <= auto_reg;
                BCE_SFR_COUNT: rdata_reg <= count_reg;
                default: rdata_reg <= 8'h00;
            endcase
        end
    end

    assign link.sfr_rdata = rdata_reg;

    ////////////////////////////////////////
    // enable stays set after a walk: the next control write restarts it
    assign req_fire = flash_req_valid && flash_req_ready;
    assign flash_req_valid = busy_reg && (req_left_reg != '0);
    assign flash_req_addr = req_addr_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_reg <= 1'b0;
        end else if (start_walk) begin
            busy_reg <= 1'b1;
        end else if (fifo_pop && (use_left_reg == BCE_LEFT_W'(1))) begin
            busy_reg <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_left_reg <= '0;
            req_addr_reg <= '0;
        end else if (start_walk) begin
            req_left_reg <= BCE_LEFT_W'({count_reg, {BCE_SECTOR_SHIFT{1'b0}}});
            req_addr_reg <= FLASH_AW'({auto_reg[BCE_AUTO_IDX_W-1:0], {BCE_SECTOR_SHIFT{1'b0}}});
        end else if (req_fire) begin
            req_left_reg <= req_left_reg - BCE_LEFT_W'(1);
            req_addr_reg <= req_addr_reg + FLASH_AW'(1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            use_left_reg <= '0;
        end else if (start_walk) begin
            use_left_reg <= BCE_LEFT_W'({count_reg, {BCE_SECTOR_SHIFT{1'b0}}});
        end else if (fifo_pop) begin
            use_left_reg <= use_left_reg - BCE_LEFT_W'(1);
        end
    end

    assign auto_busy = busy_reg;
    assign link.cpu_stall = busy_reg;

    ////////////////////////////////////////
    // flash data buffer; a full buffer holds the flash off
    assign fifo_full = (fifo_cnt_reg == CNT_W'(FIFO_DEPTH));
    assign fifo_valid = (fifo_cnt_reg != '0);
    assign flash_rsp_ready = !fifo_full;
    assign fifo_push = flash_rsp_valid && !fifo_full;
    // drained only by a walk, and never in a cycle that writes the result
    assign fifo_pop = fifo_valid && busy_reg && !result_busy;

    always_ff @(posedge hclk) begin
        if (fifo_push) begin
            fifo_mem[fifo_wr_reg] <= flash_rsp_data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fifo_wr_reg <= '0;
            fifo_rd_reg <= '0;
        end else begin
            if (fifo_push) begin
                fifo_wr_reg <= (fifo_wr_reg == PTR_W'(FIFO_DEPTH - 1)) ? '0 : fifo_wr_reg + PTR_W'(1);
            end
            if (fifo_pop) begin
                fifo_rd_reg <= (fifo_rd_reg == PTR_W'(FIFO_DEPTH - 1)) ? '0 : fifo_rd_reg + PTR_W'(1);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fifo_cnt_reg <= '0;
        end else if (fifo_push && !fifo_pop) begin
            fifo_cnt_reg <= fifo_cnt_reg + CNT_W'(1);
        end else if (fifo_pop && !fifo_push) begin
            fifo_cnt_reg <= fifo_cnt_reg - CNT_W'(1);
        end
    end

endmodule

// File: design/bce_controller.sv
// ahb-lite slave that turns bus transfers into register accesses of the crc engine
`timescale 1ns/1ps
module bce_controller
    import bce_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // register port to the engine
    bce_link_if.ctl link
);

    bce_ctl_state_t state_reg;
    logic sfr_wr_reg;
    logic sfr_rd_reg;
    logic [7:0] sfr_addr_reg;
    logic [7:0] sfr_wdata_reg;
    logic [31:0] hrdata_reg;
    logic accept;
    logic in_window;

    ////////////////////////////////////////
    // address phase
    assign hreadyout = (state_reg == BCE_ST_IDLE) || (state_reg == BCE_ST_DONE);
    assign accept = hsel && htrans[1] && hready && hreadyout;
    assign in_window = (haddr < BCE_AHB_WINDOW_TOP);
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;

    ////////////////////////////////////////
    // the wait state holds the bus while the cpu is stalled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= BCE_ST_IDLE;
        end else begin
            case (state_reg)
                BCE_ST_IDLE, BCE_ST_DONE: begin
                    if (accept && in_window) begin
                        state_reg <= hwrite ? BCE_ST_WDATA : BCE_ST_ISSUE;
                    end else if (accept) begin
                        state_reg <= BCE_ST_DONE;
                    end else begin
                        state_reg <= BCE_ST_IDLE;
                    end
                end
                BCE_ST_WDATA: state_reg <= BCE_ST_ISSUE;
                BCE_ST_ISSUE: state_reg <= BCE_ST_WAIT;
                BCE_ST_WAIT: begin
                    if (!link.cpu_stall) begin
                        state_reg <= BCE_ST_DONE;
                    end
                end
                default: state_reg <= BCE_ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////
    // strobes to the engine, one cycle each
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sfr_wr_reg <= 1'b0;
            sfr_rd_reg <= 1'b0;
        end else begin
            sfr_wr_reg <= (state_reg == BCE_ST_WDATA);
            sfr_rd_reg <= accept && in_window && !hwrite;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sfr_addr_reg <= 8'h00;
            sfr_wdata_reg <= 8'h00;
        end else begin
            if (accept && in_window) begin
                sfr_addr_reg <= haddr[9:2];
            end
            if (state_reg == BCE_ST_WDATA) begin
                sfr_wdata_reg <= hwdata[7:0];
            end
        end
    end

    assign link.sfr_wr = sfr_wr_reg;
    assign link.sfr_rd = sfr_rd_reg;
    assign link.sfr_addr = sfr_addr_reg;
    assign link.sfr_wdata = sfr_wdata_reg;

    ////////////////////////////////////////
    // read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (accept && !in_window) begin
            // status answers at once so software can poll without waiting
            hrdata_reg <= (!hwrite && haddr == BCE_AHB_STATUS) ? {31'h0000_0000, link.cpu_stall} : 32'h0000_0000;
        end else if (state_reg == BCE_ST_WAIT && !link.cpu_stall) begin
            hrdata_reg <= {24'h00_0000, link.sfr_rdata};
        end
    end

endmodule

// File: bench/bce_link_sva.sv
// assertions on the register port between the controller and the crc engine
`timescale 1ns/1ps
module bce_link_sva
    import bce_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // register port
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic cpu_stall
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic auto_en_reg;
    logic [7:0] count_reg;
    logic [7:0] input_reg;
    logic sel_reg;
    logic val_reg;
    logic [1:0] ptr_reg;
    logic fresh_reg;
    logic fresh_val_reg;
    logic [19:0] stall_cnt_reg;
    wire logic wr_ctrl = sfr_wr && sfr_addr == BCE_SFR_CTRL;
    wire logic data_acc = (sfr_wr || sfr_rd) && sfr_addr == BCE_SFR_DATA;

    ////////////////////////////////////////
    // shadow of what software last programmed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            auto_en_reg <= 1'b0;
            count_reg <= 8'h00;
            input_reg <= 8'h00;
        end else if (sfr_wr) begin
            case (sfr_addr)
                BCE_SFR_AUTO: auto_en_reg <= sfr_wdata[BCE_AUTO_EN_BIT];
                BCE_SFR_COUNT: count_reg <= sfr_wdata;
                BCE_SFR_INPUT: input_reg <= sfr_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_reg <= 1'b0;
            val_reg <= 1'b0;
            ptr_reg <= 2'b00;
        end else if (wr_ctrl) begin
            sel_reg <= sfr_wdata[BCE_CTRL_SEL_BIT];
            val_reg <= sfr_wdata[BCE_CTRL_VAL_BIT];
            ptr_reg <= sfr_wdata[1:0];
        end else if (data_acc) begin
            ptr_reg <= ptr_reg + 2'd1;
        end
    end

    // result untouched since the last init
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fresh_reg <= 1'b0;
            fresh_val_reg <= 1'b0;
        end else if (wr_ctrl && sfr_wdata[BCE_CTRL_INIT_BIT]) begin
            fresh_reg <= 1'b1;
            fresh_val_reg <= sfr_wdata[BCE_CTRL_VAL_BIT];
        end else if (cpu_stall || (sfr_wr && (sfr_addr == BCE_SFR_INPUT || sfr_addr == BCE_SFR_DATA))) begin
            fresh_reg <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stall_cnt_reg <= 20'h0_0000;
        end else begin
            stall_cnt_reg <= cpu_stall ? stall_cnt_reg + 20'h0_0001 : 20'h0_0000;
        end
    end

    ////////////////////////////////////////
    chk_strobe_excl: assert property (!(sfr_wr && sfr_rd))
        else $error("read and write strobes together");
    chk_walk_start: assert property (wr_ctrl && auto_en_reg && count_reg != 8'h00 |=> cpu_stall)
        else $error("walk did not start");
    chk_walk_idle: assert property (!cpu_stall && !(wr_ctrl && auto_en_reg) |=> !cpu_stall)
        else $error("stall without a start write");
    chk_stall_quiet: assert property (cpu_stall |-> !sfr_wr && !sfr_rd)
        else $error("register access while stalled");
    chk_walk_length: assert property ($fell(cpu_stall) |-> stall_cnt_reg >= {count_reg, 10'h000})
        else $error("walk shorter than its sectors");
    chk_ctrl_read: assert property (sfr_rd && sfr_addr == BCE_SFR_CTRL
        |=> sfr_rdata == {3'b000, sel_reg, 1'b0, val_reg, ptr_reg})
        else $error("control readback wrong");
    chk_input_read: assert property (sfr_rd && sfr_addr == BCE_SFR_INPUT |=> sfr_rdata == input_reg)
        else $error("input byte readback wrong");
    chk_init_value: assert property (sfr_rd && sfr_addr == BCE_SFR_DATA && fresh_reg
        |=> sfr_rdata == {8{fresh_val_reg}})
        else $error("start value wrong");
    chk_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
        else $error("read data changed without a read");

    cover property (wr_ctrl && auto_en_reg && count_reg != 8'h00);
    cover property ($fell(cpu_stall));
    cover property (sfr_rd && sfr_addr == BCE_SFR_DATA && fresh_reg);
endmodule

// File: bench/tb_top.sv
// self-checking bench: ahb master, flash responder, crc reference
`timescale 1ns/1ps
module tb_top
    import bce_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout;
    logic [31:0] hrdata;
    logic flash_req_valid;
    logic flash_req_ready = 1'b0;
    logic [15:0] flash_req_addr;
    logic flash_rsp_valid = 1'b0;
    logic flash_rsp_ready;
    logic [7:0] flash_rsp_data = 8'h00;
    logic [31:0] seed = 32'h0000_c763;
    logic [31:0] fseed = 32'h0000_c763;
    logic [15:0] aq[$];
    int n_mismatch = 0;
    int n_tests = 0;
    logic [7:0] ra [5] = '{BCE_SFR_CTRL, BCE_SFR_INPUT, BCE_SFR_AUTO, BCE_SFR_COUNT, 8'h90};
    logic [39:0] tv [5] = '{40'h63, 40'h8C, 40'h7D, 40'hAA_BBCC, 40'hAA_BBCC};
    int tl [5] = '{1, 1, 1, 3, 5};
    logic [15:0] to [5] = '{16'hBD35, 16'hB1F4, 16'h4ECA, 16'h6CF6, 16'hB166};

    bce_link_if bce_link_if_inst ();
    bce_controller bce_controller_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(), .link(bce_link_if_inst));
    bce_device bce_device_inst (.hclk(hclk), .hresetn(hresetn), .link(bce_link_if_inst),
        .flash_req_valid(flash_req_valid), .flash_req_ready(flash_req_ready), .flash_req_addr(flash_req_addr),
        .flash_rsp_valid(flash_rsp_valid), .flash_rsp_ready(flash_rsp_ready), .flash_rsp_data(flash_rsp_data),
        .auto_busy());
    bce_link_sva bce_link_sva_inst (.hclk(hclk), .hresetn(hresetn), .sfr_wr(bce_link_if_inst.sfr_wr),
        .sfr_rd(bce_link_if_inst.sfr_rd), .sfr_addr(bce_link_if_inst.sfr_addr),
        .sfr_wdata(bce_link_if_inst.sfr_wdata), .sfr_rdata(bce_link_if_inst.sfr_rdata),
        .cpu_stall(bce_link_if_inst.cpu_stall));

    ////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [7:0] fbyte(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction

    function automatic logic [31:0] crc_ref(input logic [31:0] r, input logic [7:0] b, input logic s16);
        logic [31:0] a;
        a = s16 ? {r[31:16], r[15:0] ^ {b, 8'h00}} : r ^ {b, 24'h00_0000};
        for (int i = 0; i < 8; i++) begin
            if (s16) begin
                a[15:0] = a[15] ? {a[14:0], 1'b0} ^ BCE_POLY16 : {a[14:0], 1'b0};
            end else begin
                a = a[31] ? {a[30:0], 1'b0} ^ BCE_POLY32 : {a[30:0], 1'b0};
            end
        end
        return a;
    endfunction

    function automatic logic [7:0] pick(input logic [31:0] r, input logic [1:0] p, input logic s16);
        return r[8 * (s16 ? {1'b0, p[0]} : p) +: 8];
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic close_out();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] x;
        ahb({22'h00_0000, a, 2'b00}, 1'b1, {24'h00_0000, d}, x);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic [31:0] x;
        ahb({22'h00_0000, a, 2'b00}, 1'b0, 32'h0000_0000, x);
        d = x[7:0];
    endtask

    task automatic check_result(input logic [31:0] r, input logic s16, input logic [1:0] p, input string m);
        logic [7:0] b;
        wr(BCE_SFR_CTRL, {3'b000, s16, 2'b00, p});
        for (int i = 0; i < 4; i++) begin
            rd(BCE_SFR_DATA, b);
            chk(32'(b), 32'(pick(r, 2'(p + i), s16)), m);
        end
        rd(BCE_SFR_CTRL, b);
        chk(32'(b), 32'({3'b000, s16, 2'b00, p}), "pointer wrap");
    endtask

    ////////////////////////////////////////
    initial begin
        forever #2 hclk = ~hclk;
    end

    // flash model: random stalls, in-order answers
    always @(posedge hclk) begin
        fseed = lfsr(fseed);
        if (flash_req_valid && flash_req_ready) begin
            aq.push_back(flash_req_addr);
        end
        if (!(flash_rsp_valid && !flash_rsp_ready)) begin
            if (aq.size() > 0 && fseed[3:2] != 2'b00) begin
                flash_rsp_valid <= 1'b1;
                flash_rsp_data <= fbyte(aq.pop_front());
            end else begin
                flash_rsp_valid <= 1'b0;
                flash_rsp_data <= ~flash_rsp_data;
            end
        end
        flash_req_ready <= fseed[5] | fseed[6];
    end

    initial begin
        repeat (80000) @(posedge hclk);
        n_mismatch++;
        close_out();
    end

    initial begin
        logic [31:0] exp, x;
        logic [7:0] b, idx, cnt;
        logic s16;
        time t0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (ra[i]) begin
            rd(ra[i], b);
            chk(32'(b), 32'h0000_0000, "reset value");
        end
        check_result(BCE_RESULT_RST, 1'b0, 2'b00, "reset result");
        for (int t = 0; t < 5; t++) begin
            wr(BCE_SFR_CTRL, 8'h1C);
            for (int k = tl[t] - 1; k >= 0; k--) begin
                wr(BCE_SFR_INPUT, 8'(tv[t] >> (8 * k)));
            end
            check_result({16'h0000, to[t]}, 1'b1, 2'b00, "table crc");
        end
        for (int m = 0; m < 4; m++) begin
            s16 = m[0];
            exp = m[1] ? BCE_START_ONES : BCE_START_ZEROS;
            wr(BCE_SFR_CTRL, {3'b000, s16, 1'b1, m[1], 2'b00});
            check_result(exp, s16, 2'b00, "start value");
            for (int k = 0; k < 6; k++) begin
                seed = lfsr(seed);
                b = seed[7:0];
                wr(BCE_SFR_INPUT, b);
                exp = crc_ref(exp, b, s16);
            end
            rd(BCE_SFR_INPUT, x[7:0]);
            chk(32'(x[7:0]), 32'(b), "input readback");
            check_result(exp, s16, seed[9:8], "stream crc");
        end
        seed = lfsr(seed);
        wr(BCE_SFR_CTRL, 8'h01);
        for (int k = 1; k < 5; k++) begin
            wr(BCE_SFR_DATA, seed[8 * (k % 4) +: 8]);
        end
        check_result(seed, 1'b0, 2'b10, "result write");
        wr(BCE_SFR_INPUT, 8'h3c);
        check_result(crc_ref(seed, 8'h3c, 1'b0), 1'b0, 2'b11, "write then feed");
        for (int m = 0; m < 2; m++) begin
            idx = 8'(3 + 2 * m);
            cnt = 8'(m + 1);
            exp = BCE_START_ONES;
            wr(BCE_SFR_CTRL, {3'b000, m[0], 4'b1100});
            wr(BCE_SFR_AUTO, 8'h80 | idx);
            wr(BCE_SFR_COUNT, cnt);
            t0 = $time;
            wr(BCE_SFR_CTRL, {3'b000, m[0], 4'b0100});
            chk(32'(($time - t0) >= cnt * 4096), 32'h0000_0001, "walk too short");
            ahb(BCE_AHB_STATUS, 1'b0, 32'h0000_0000, x);
            chk(x, 32'h0000_0000, "still stalled");
            wr(BCE_SFR_AUTO, idx);
            for (int a = 0; a < cnt * BCE_SECTOR_BYTES; a++) begin
                exp = crc_ref(exp, fbyte(16'(idx * BCE_SECTOR_BYTES + a)), m[0]);
            end
            check_result(exp, m[0], 2'b00, "auto crc");
        end
        close_out();
    end
endmodule
